// ### shared/pcd_pkg.sv
// Shared constants and carrier types for the protocol setup and slot status block
`default_nettype none

package pcd_pkg;

    // Bus and register geometry
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 16;
    localparam int unsigned SLOT_W = 11;
    localparam int unsigned NUM_CHAN = 2;
    localparam int unsigned NUM_CFG = 31;
    localparam int unsigned CFG_AW = 5;
    localparam int unsigned IDX_W = 12;

    // Register indices; the byte address is four times the index
    localparam logic [11:0] IDX_LAST_SLOT_A = 12'h09c;
    localparam logic [11:0] IDX_LAST_SLOT_B = 12'h09e;
    localparam logic [11:0] IDX_CFG_BASE = 12'h0a0;
    localparam logic [11:0] IDX_CFG_SPAN = 12'h03e;

    // Reset values
    localparam logic [10:0] LAST_SLOT_RST = 11'h000;
    localparam logic [10:0] NO_DYN_TX_SLOT = 11'h000;
    localparam logic [15:0] CFG_RST = 16'h0000;

    // Field placement inside the protocol setup words: word, lsb, width
    localparam int unsigned APO_REG = 0, APO_LSB = 10, APO_W = 6;
    localparam int unsigned SSL_REG = 0, SSL_LSB = 0, SSL_W = 10;
    localparam int unsigned MSAAP_REG = 2, MSAAP_LSB = 10, MSAAP_W = 6;
    localparam int unsigned MSAPO_REG = 3, MSAPO_LSB = 10, MSAPO_W = 5;
    localparam int unsigned SWAAP_REG = 6, SWAAP_LSB = 0, SWAAP_W = 8;
    localparam int unsigned WUCH_REG = 10, WUCH_BIT = 15;
    localparam int unsigned KCRC_REG = 12, KCRC_LSB = 0, KCRC_W = 11;
    localparam int unsigned SSAAP_REG = 13, SSAAP_LSB = 0, SSAAP_W = 10;
    localparam int unsigned LTO_HI_REG = 14, LTO_LO_REG = 15, LTO_HI_W = 5;
    localparam int unsigned NLT_HI_REG = 16, NLT_LO_REG = 17, NLT_HI_W = 9;

    // Engine side slot report for one channel
    typedef struct packed {
        logic valid;
        logic [10:0] slot;
    } pcd_slot_report_t;

    // Decoded parameters handed to the protocol engine
    typedef struct packed {
        logic wakeup_chan_b;
        logic [10:0] key_slot_header_crc;
        logic [10:0] static_slot_mt;
        logic static_slot_mismatch;
        logic [6:0] minislot_mt;
        logic [8:0] symbol_window_mt;
        logic [25:0] noise_listen_ut;
        logic [21:0] listen_timeout_ut;
    } pcd_engine_cfg_t;

    // Whole state of the top module
    typedef struct packed {
        pcd_engine_cfg_t cfg;
        logic [NUM_CHAN-1:0][10:0] last_slot;
        logic [NUM_CHAN-1:0][10:0] seen_slot;
        logic [NUM_CHAN-1:0] seen_any;
        logic [15:0] stat_rdata;
        logic rd_cfg;
        logic slverr;
        logic [NUM_CHAN-1:0] wake_send;
    } pcd_state_t;

endpackage : pcd_pkg

`default_nettype wire

// ### src/pcd_cfg_store.sv
// Protocol setup word store with registered read port and parallel view
`default_nettype none

module pcd_cfg_store #(
    parameter int unsigned DEPTH = 31,
    parameter int unsigned WIDTH = 16,
    parameter int unsigned AW = 5
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data,
    // Parallel view for the engine
    output logic [DEPTH-1:0][WIDTH-1:0] words
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] words;
        logic [WIDTH-1:0] rd_data;
    } pcd_store_state_t;

    pcd_store_state_t state;
    pcd_store_state_t next_state;

    // Write and read updates; indices past the depth are dropped
    always_comb begin
        next_state = state;
        if (wr_en && (32'(wr_idx) < DEPTH)) begin
            next_state.words[wr_idx] = wr_data;
        end
        if (rd_en) begin
            next_state.rd_data = (32'(rd_idx) < DEPTH) ? state.words[rd_idx] : '0;
        end
    end

    // All words return to the reset value
    always_ff @(posedge clock) begin
        if (srst) begin
            next_state_reset: state <= '{words: {DEPTH{pcd_pkg::CFG_RST}}, rd_data: '0};
        end else begin
            state <= next_state;
        end
    end

    assign rd_data = state.rd_data;
    assign words = state.words;

endmodule : pcd_cfg_store

`default_nettype wire

// ### src/pcd_top.sv
// Protocol setup registers and last dynamic transmit slot status, APB slave
//
// Functional notes
// - Per channel, latch last dynamic slot at segment end
// - No channel A frame: load zero
// - No channel B frame: load zero
// - Engine takes parameters from setup register fields
// - Wakeup channel 0 selects A, 1 B
// - Key slot header CRC is 11 bits, software-supplied
// - Static slot after action point: length minus offset minus one
// - Minislot after action point: length minus offset minus one
// - Symbol window after action point: length minus offset minus one
// - Noise listen timeout minus one, split over two words
//
// The implementer's own choice: the APB register port.
`default_nettype none

module pcd_top #(
    parameter int unsigned ADDR_W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,

    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Protocol engine events
    input wire pcd_pkg::pcd_slot_report_t tx_report_a,
    input wire pcd_pkg::pcd_slot_report_t tx_report_b,
    input wire logic dyn_seg_end,
    input wire logic wakeup_req,

    // Protocol engine configuration and wakeup steering
    output logic [pcd_pkg::NUM_CFG-1:0][15:0] protocol_setup_register,
    output pcd_pkg::pcd_engine_cfg_t engine_cfg,
    output logic wakeup_send_a,
    output logic wakeup_send_b,

    // Status values as the host sees them
    output logic [10:0] last_dyn_slot_value_a,
    output logic [10:0] last_dyn_slot_value_b
);

    pcd_pkg::pcd_state_t state;
    pcd_pkg::pcd_state_t next_state;

    // Bus phase decode
    logic setup_phase;
    logic access_phase;
    logic [11:0] idx;
    logic addr_ok;
    logic [11:0] cfg_off;
    logic hit_cfg;
    logic hit_last_a;
    logic hit_last_b;
    logic hit_any;
    logic [4:0] cfg_n;

    // Store interface
    logic store_wr_en;
    logic store_rd_en;
    logic [15:0] store_wr_data;
    logic [15:0] store_rd_data;
    logic [15:0] cur_word;
    logic [pcd_pkg::NUM_CFG-1:0][15:0] words;

    // Channel reports gathered into one array for the per-channel loop
    pcd_pkg::pcd_slot_report_t [pcd_pkg::NUM_CHAN-1:0] reports;
    logic [pcd_pkg::NUM_CHAN-1:0][10:0] next_last;
    logic [pcd_pkg::NUM_CHAN-1:0][10:0] next_seen;
    logic [pcd_pkg::NUM_CHAN-1:0] next_any;

    assign reports[0] = tx_report_a;
    assign reports[1] = tx_report_b;

    // Setup cycle prepares the answer, access cycle completes it
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;

    // Word index from the byte address; misaligned or out of range misses
    assign idx = paddr[13:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (32'(paddr) < 32'h0000_4000);
    assign cfg_off = idx - pcd_pkg::IDX_CFG_BASE;
    assign cfg_n = cfg_off[5:1];

    // Setup words sit on even indices, one word per index pair
    always_comb begin
        hit_cfg = addr_ok && (idx >= pcd_pkg::IDX_CFG_BASE);
        hit_cfg = hit_cfg && (cfg_off <= pcd_pkg::IDX_CFG_SPAN - 12'h002);
        hit_cfg = hit_cfg && !cfg_off[0];
    end

    assign hit_last_a = addr_ok && (idx == pcd_pkg::IDX_LAST_SLOT_A);
    assign hit_last_b = addr_ok && (idx == pcd_pkg::IDX_LAST_SLOT_B);
    assign hit_any = hit_cfg || hit_last_a || hit_last_b;

    // Byte lanes 0 and 1 carry the 16-bit words; lanes 2 and 3 have no storage
    assign cur_word = words[cfg_n];
    assign store_wr_data[7:0] = pstrb[0] ? pwdata[7:0] : cur_word[7:0];
    assign store_wr_data[15:8] = pstrb[1] ? pwdata[15:8] : cur_word[15:8];

    // A write lands at the access edge, so a read set up next sees it
    assign store_wr_en = access_phase && pwrite && hit_cfg;
    assign store_rd_en = setup_phase && !pwrite && hit_cfg;

    pcd_cfg_store #(
        .DEPTH(pcd_pkg::NUM_CFG),
        .WIDTH(pcd_pkg::REG_W),
        .AW(pcd_pkg::CFG_AW)
    ) u_store (
        .clock(clock),
        .srst(srst),
        .wr_en(store_wr_en),
        .wr_idx(cfg_n),
        .wr_data(store_wr_data),
        .rd_en(store_rd_en),
        .rd_idx(cfg_n),
        .rd_data(store_rd_data),
        .words(words)
    );

    // Per-channel capture of the latest dynamic slot transmitted in
    for (genvar ch = 0; ch < pcd_pkg::NUM_CHAN; ch++) begin : g_chan
        always_comb begin
            next_seen[ch] = state.seen_slot[ch];
            next_any[ch] = state.seen_any[ch];
            next_last[ch] = state.last_slot[ch];
            // A report in the closing cycle still counts for this segment
            if (reports[ch].valid) begin
                next_seen[ch] = reports[ch].slot;
                next_any[ch] = 1'b1;
            end
            if (dyn_seg_end) begin
                if (next_any[ch]) begin
                    next_last[ch] = next_seen[ch];
                end else begin
                    next_last[ch] = pcd_pkg::NO_DYN_TX_SLOT;
                end
                // Start afresh for the next segment
                next_seen[ch] = pcd_pkg::LAST_SLOT_RST;
                next_any[ch] = 1'b0;
            end
        end
    end

    // Next state: bus answer, status capture, decoded engine parameters
    always_comb begin
        logic [5:0] apo;
        logic [9:0] ssl;
        logic [9:0] ssaap;
        logic [5:0] msaap;
        logic [4:0] msapo;
        logic [7:0] swaap;
        logic [24:0] nlt;
        logic [20:0] lto;
        apo = '0;
        ssl = '0;
        ssaap = '0;
        msaap = '0;
        msapo = '0;
        swaap = '0;
        nlt = '0;
        lto = '0;
        next_state = state;

        // Status registers move only on engine events; bus writes never reach them
        next_state.last_slot = next_last;
        next_state.seen_slot = next_seen;
        next_state.seen_any = next_any;

        // Read data and error are prepared in the setup cycle
        if (setup_phase) begin
            next_state.rd_cfg = hit_cfg;
            next_state.slverr = !hit_any;
            if (hit_last_a) begin
                next_state.stat_rdata = {5'h00, state.last_slot[0]};
            end else if (hit_last_b) begin
                next_state.stat_rdata = {5'h00, state.last_slot[1]};
            end else begin
                next_state.stat_rdata = 16'h0000;
            end
        end

        // Raw fields pulled from the setup words
        apo = words[pcd_pkg::APO_REG][pcd_pkg::APO_LSB +: pcd_pkg::APO_W];
        ssl = words[pcd_pkg::SSL_REG][pcd_pkg::SSL_LSB +: pcd_pkg::SSL_W];
        ssaap = words[pcd_pkg::SSAAP_REG][pcd_pkg::SSAAP_LSB +: pcd_pkg::SSAAP_W];
        msaap = words[pcd_pkg::MSAAP_REG][pcd_pkg::MSAAP_LSB +: pcd_pkg::MSAAP_W];
        msapo = words[pcd_pkg::MSAPO_REG][pcd_pkg::MSAPO_LSB +: pcd_pkg::MSAPO_W];
        swaap = words[pcd_pkg::SWAAP_REG][pcd_pkg::SWAAP_LSB +: pcd_pkg::SWAAP_W];
        nlt = {words[pcd_pkg::NLT_HI_REG][pcd_pkg::NLT_HI_W-1:0],
               words[pcd_pkg::NLT_LO_REG]};
        lto = {words[pcd_pkg::LTO_HI_REG][pcd_pkg::LTO_HI_W-1:0],
               words[pcd_pkg::LTO_LO_REG]};

        // Wakeup channel and key slot CRC pass straight through
        next_state.cfg.wakeup_chan_b = words[pcd_pkg::WUCH_REG][pcd_pkg::WUCH_BIT];
        next_state.cfg.key_slot_header_crc =
            words[pcd_pkg::KCRC_REG][pcd_pkg::KCRC_LSB +: pcd_pkg::KCRC_W];

        // Action point offset is stored minus one, so add back two in total
        next_state.cfg.static_slot_mt = 11'(ssaap) + 11'(apo) + 11'h002;
        next_state.cfg.static_slot_mismatch =
            (11'(ssaap) + 11'(apo) + 11'h002) != 11'(ssl);
        next_state.cfg.minislot_mt = 7'(msaap) + 7'(msapo) + 7'h02;
        next_state.cfg.symbol_window_mt = 9'(swaap) + 9'(apo) + 9'h002;

        // Timeouts are stored minus one across a word pair
        next_state.cfg.noise_listen_ut = 26'(nlt) + 26'h000_0001;
        next_state.cfg.listen_timeout_ut = 22'(lto) + 22'h00_0001;

        // Wakeup request goes out on the selected channel only
        next_state.wake_send[0] = wakeup_req && !state.cfg.wakeup_chan_b;
        next_state.wake_send[1] = wakeup_req && state.cfg.wakeup_chan_b;
    end

    // Single register stage for the whole state
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access_phase && state.slverr;

    // Upper half of the word reads as zero
    assign prdata = {16'h0000, state.rd_cfg ? store_rd_data : state.stat_rdata};

    // Engine view of the setup words and their decoded values
    assign protocol_setup_register = words;
    assign engine_cfg = state.cfg;
    assign wakeup_send_a = state.wake_send[0];
    assign wakeup_send_b = state.wake_send[1];
    assign last_dyn_slot_value_a = state.last_slot[0];
    assign last_dyn_slot_value_b = state.last_slot[1];

endmodule : pcd_top

`default_nettype wire

// ### tb/pcd_checker.sv
// Checker for the setup registers and the last dynamic slot status
`default_nettype none
module pcd_checker #(
    parameter int unsigned ADDR_W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Engine side
    input wire pcd_pkg::pcd_slot_report_t tx_report_a,
    input wire pcd_pkg::pcd_slot_report_t tx_report_b,
    input wire logic dyn_seg_end,
    input wire logic wakeup_req,
    input wire logic [pcd_pkg::NUM_CFG-1:0][15:0] protocol_setup_register,
    input wire pcd_pkg::pcd_engine_cfg_t engine_cfg,
    input wire logic wakeup_send_a,
    input wire logic wakeup_send_b,
    input wire logic [10:0] last_dyn_slot_value_a,
    input wire logic [10:0] last_dyn_slot_value_b
);
    wire logic [pcd_pkg::NUM_CFG-1:0][15:0] w;
    logic [1:0] seen;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    assign w = protocol_setup_register;
    // Reports seen in the running segment; a new segment starts clean
    always_ff @(posedge clock) begin
        seen <= (srst || dyn_seg_end) ? 2'b00 : seen | {tx_report_b.valid, tx_report_a.valid};
    end
    sequence rpt_end_a;
        tx_report_a.valid ##1 (dyn_seg_end && !tx_report_a.valid);
    endsequence
    latest_slot_a:
    assert property (rpt_end_a |=> last_dyn_slot_value_a == $past(tx_report_a.slot, 2))
    else $error("channel A status not the latest slot");
    closing_rpt_a:
    assert property (dyn_seg_end && tx_report_b.valid |=> last_dyn_slot_value_b == $past(tx_report_b.slot))
    else $error("channel B status missed a closing report");
    empty_seg_a:
    assert property (dyn_seg_end && !seen[0] && !tx_report_a.valid |=> last_dyn_slot_value_a == 11'h000)
    else $error("channel A status not zero");
    empty_chan_b_a:
    assert property (dyn_seg_end && !seen[1] && !tx_report_b.valid |=> last_dyn_slot_value_b == 11'h000)
    else $error("channel B status not zero");
    status_hold_a:
    assert property (!dyn_seg_end |=> $stable(last_dyn_slot_value_a))
    else $error("channel A status moved between segment ends");
    wake_chan_a:
    assert property (wakeup_req && !engine_cfg.wakeup_chan_b |=> wakeup_send_a && !wakeup_send_b)
    else $error("wakeup not on channel A");
    wake_other_a:
    assert property (wakeup_req && engine_cfg.wakeup_chan_b |=> wakeup_send_b && !wakeup_send_a)
    else $error("wakeup not on channel B");
    key_crc_a:
    assert property (!$past(srst) |-> engine_cfg.key_slot_header_crc == $past(w[12][10:0]))
    else $error("key slot crc not passed on");
    static_slot_a:
    assert property (!$past(srst) |-> engine_cfg.static_slot_mt ==
        11'($past(w[13][9:0]) + $past(w[0][15:10]) + 11'h002))
    else $error("static slot length wrong");
    minislot_len_a:
    assert property (!$past(srst) |-> engine_cfg.minislot_mt ==
        7'($past(w[2][15:10]) + $past(w[3][14:10]) + 7'h02))
    else $error("minislot length wrong");
    symbol_win_a:
    assert property (!$past(srst) |-> engine_cfg.symbol_window_mt ==
        9'($past(w[6][7:0]) + $past(w[0][15:10]) + 9'h002))
    else $error("symbol window length wrong");
    noise_listen_a:
    assert property (!$past(srst) |-> engine_cfg.noise_listen_ut ==
        26'({$past(w[16][8:0]), $past(w[17])} + 26'h0000001))
    else $error("noise listen timeout wrong");
    status_access_a:
    assert property (psel && penable && (paddr == 16'h0270 || paddr == 16'h0278)
        |-> !pslverr && prdata[31:16] == 16'h0000)
    else $error("status access refused or upper bits set");
endmodule : pcd_checker

bind pcd_top pcd_checker #(.ADDR_W(ADDR_W)) pcd_checker_inst (.clock, .srst, .psel, .penable,
    .paddr, .prdata, .pslverr, .tx_report_a, .tx_report_b, .dyn_seg_end, .wakeup_req,
    .protocol_setup_register, .engine_cfg, .wakeup_send_a, .wakeup_send_b,
    .last_dyn_slot_value_a, .last_dyn_slot_value_b);
`default_nettype wire

// ### tb/pcd_top_tb.sv
// Self-checking bench for the setup registers and the last dynamic slot status
`default_nettype none
module pcd_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [15:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic [31:0] q;
        logic e;
    } pcd_row_t;
    logic clock, srst, psel, penable, pwrite, pready, pslverr, er;
    logic dyn_seg_end, wakeup_req, wakeup_send_a, wakeup_send_b;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    pcd_pkg::pcd_slot_report_t tx_report_a, tx_report_b;
    logic [pcd_pkg::NUM_CFG-1:0][15:0] protocol_setup_register;
    pcd_pkg::pcd_engine_cfg_t engine_cfg;
    logic [10:0] last_dyn_slot_value_a, last_dyn_slot_value_b;
    int miscompares = 0;
    int n_tests = 0;
    // Address, write data, strobes, read back, error; status and holes come last
    pcd_row_t rows [15] = '{
        '{16'h0280, 32'hffff0c15, 4'hf, 32'h0c15, 1'b0}, '{16'h0290, 32'h1000, 4'hf, 32'h1000, 1'b0},
        '{16'h0298, 32'h0800, 4'hf, 32'h0800, 1'b0}, '{16'h02b0, 32'h0010, 4'hf, 32'h0010, 1'b0},
        '{16'h02d0, 32'h8000, 4'hf, 32'h8000, 1'b0}, '{16'h02e0, 32'h07ff, 4'hf, 32'h07ff, 1'b0},
        '{16'h02e8, 32'h0010, 4'hf, 32'h0010, 1'b0}, '{16'h0300, 32'h0001, 4'hf, 32'h0001, 1'b0},
        '{16'h0308, 32'hffff, 4'hf, 32'hffff, 1'b0}, '{16'h0370, 32'h8001, 4'hf, 32'h8001, 1'b0},
        '{16'h0370, 32'haaaa, 4'h1, 32'h80aa, 1'b0}, '{16'h0284, 32'h1234, 4'hf, 32'h0, 1'b1},
        '{16'h0282, 32'h1234, 4'hf, 32'h0, 1'b1}, '{16'h0278, 32'h07ff, 4'hf, 32'h0, 1'b0},
        '{16'h0270, 32'h07ff, 4'hf, 32'h0, 1'b0}};

    pcd_top #(.ADDR_W(16)) pcd_top_inst (.clock, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .tx_report_a, .tx_report_b, .dyn_seg_end,
        .wakeup_req, .protocol_setup_register, .engine_cfg, .wakeup_send_a, .wakeup_send_b,
        .last_dyn_slot_value_a, .last_dyn_slot_value_b);

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; the request holds until pready is seen at an edge
    task xfer(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        check({31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // The send pulse stands for the one cycle after the request; look at it mid-cycle
    task wake(input logic [1:0] exp);
        @(posedge clock);
        wakeup_req <= 1'b1;
        @(posedge clock);
        wakeup_req <= 1'b0;
        @(negedge clock);
        check({30'h0, wakeup_send_a, wakeup_send_b}, {30'h0, exp});
    endtask : wake

    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // Free-running bus clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Watchdog, far beyond the roughly 120 cycles the tests need
    initial begin
        repeat (3000) @(posedge clock);
        miscompares++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        {srst, psel, penable, pwrite, dyn_seg_end, wakeup_req} = 6'b100000;
        {paddr, pwdata, pstrb} = '0;
        tx_report_a = '0;
        tx_report_b = '0;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].a, rows[i].d, rows[i].s);
            check({31'h0, er}, {31'h0, rows[i].e});
            xfer(1'b0, rows[i].a, 32'h0, 4'h0);
            check(rd, rows[i].q);
        end
        // Offset plus two everywhere; static slot written consistent so no mismatch
        check(32'({engine_cfg.static_slot_mt, engine_cfg.static_slot_mismatch,
            engine_cfg.minislot_mt, engine_cfg.symbol_window_mt}),
            32'({11'h015, 1'b0, 7'h08, 9'h015}));
        check(32'(engine_cfg.noise_listen_ut), 32'h0002_0000);
        check(32'(engine_cfg.key_slot_header_crc), 32'h7ff);
        // Listen timeout words were never written, so the value is zero plus one
        check(32'(engine_cfg.listen_timeout_ut), 32'h0000_0001);
        wake(2'b01);
        xfer(1'b1, 16'h02d0, 32'h0, 4'hf);
        wake(2'b10);
        // Latest report wins over the larger one
        @(posedge clock);
        tx_report_a <= '{1'b1, 11'h009};
        @(posedge clock);
        tx_report_a <= '{1'b1, 11'h005};
        @(posedge clock);
        tx_report_a <= '0;
        dyn_seg_end <= 1'b1;
        @(posedge clock);
        dyn_seg_end <= 1'b0;
        xfer(1'b0, 16'h0270, 32'h0, 4'h0);
        check(rd, 32'h005);
        xfer(1'b0, 16'h0278, 32'h0, 4'h0);
        check(rd, 32'h0);
        // Report on the closing cycle counts; one just after waits for the next end
        @(posedge clock);
        tx_report_b <= '{1'b1, 11'h7ff};
        dyn_seg_end <= 1'b1;
        @(posedge clock);
        tx_report_b <= '0;
        dyn_seg_end <= 1'b0;
        tx_report_a <= '{1'b1, 11'h003};
        @(posedge clock);
        tx_report_a <= '0;
        check(32'({last_dyn_slot_value_a, last_dyn_slot_value_b}), 32'h7ff);
        // Second reset in mid-run clears words and status
        @(posedge clock);
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        xfer(1'b0, 16'h0280, 32'h0, 4'h0);
        check(rd, 32'h0);
        check(32'(last_dyn_slot_value_b), 32'h0);
        report_and_stop();
    end
endmodule : pcd_top_tb
`default_nettype wire
